//--- hdl/sxc_status_ctrl.sv
/*
 Status-word and exception entry/exit controller of the core.
 Assumes the pipeline presents one instruction boundary per end_of_instr
 pulse, exception causes as same-clock levels, and interrupt pins as
 asynchronous active-low levels held until serviced.
*/
`timescale 1ns/10ps
`default_nettype none
// How it works
// - One current status word and five saved words, readable only in own mode.
// - Flags N Z C V updated by ALU, status writes, load-multiple; tested by conditions.
// - Full-width state: all instructions conditional; compressed: only branch.
// - Low eight bits are control; exception changes them; writable only privileged.
// - Set normal mask ignores normal request; set fast mask ignores fast request.
// - State bit set in compressed state, driven continuously on state output.
// - Mode codes: 10000 usr,10001 fiq,10010 irq,10011 svc,10111 abt,11011 und,11111 sys.
// - Fast mode banks r8-r14; other exception modes bank r13-r14; usr/sys share.
// - Link value: PC+4/PC+2 for link, trap, undefined; PC+4 prefetch abort/irqs; PC+8 data abort.
// - Entry copies current status word to saved word of entered mode.
// - Entry forces mode field then redirects fetch to vector.
// - Interrupt entry sets mask bits to stop uncontrolled nesting.
// - Exceptions run full-width; state bit cleared when vector loaded.
// - Exit loads PC from link minus 0, 4 or 8 and restores saved word.
// - Restore returns state bit and both masks to pre-exception values.
// - With fast mask clear, synced fast input checked every instruction end; not in the cycle after an entry or while halted.
// - Normal interrupt level-sensitive, below fast, masked on fast entry.
// - Supervisor link value after reset is undefined; no return from reset.
// - Vectors from zero; reset/fast set both masks; others per table.
// - Priority: reset, data abort, fast, normal, prefetch, undefined, trap.
// - Reset release: supervisor mode, both masks set, state clear, fetch zero.
module sxc_status_ctrl
    import sxc_pkg::*;
(
    input  wire logic        CLK_SYS_I,
    input  wire logic        RESETN_I,
    input  wire logic        FAST_IRQ_IN_N_I,
    input  wire logic        NORMAL_IRQ_IN_N_I,
    input  wire logic        END_OF_INSTR_I,
    input  wire logic [31:0] PC_I,
    input  wire logic        DATA_ABORT_I,
    input  wire logic        PREFETCH_ABORT_I,
    input  wire logic        UNDEF_INSTR_I,
    input  wire logic        SOFTWARE_TRAP_I,
    input  wire logic        BRANCH_WITH_LINK_I,
    input  wire logic        FLAGS_WE_I,
    input  wire logic [3:0]  FLAGS_I,
    input  wire logic        STATUS_WR_I,
    input  wire logic        STATUS_WR_SAVED_I,
    input  wire logic [31:0] STATUS_WDATA_I,
    input  wire logic        STATE_SET_I,
    input  wire logic        STATE_VALUE_I,
    input  wire logic        RETURN_I,
    input  wire logic [2:0]  RETURN_KIND_I,
    input  wire logic [31:0] LINK_VALUE_I,
    input  wire logic        COND_BRANCH_I,
    input  wire logic [3:0]  COND_CODE_I,
    output logic [31:0]      CURRENT_STATUS_WORD_O,
    output logic [31:0]      SAVED_STATUS_WORD_O,
    output logic             SAVED_VALID_O,
    output logic             STATE_OUTPUT_SIGNAL_O,
    output logic             COND_PASS_O,
    output logic             EXC_TAKE_O,
    output logic [31:0]      FETCH_ADDR_O,
    output logic             LINK_WE_O,
    output logic [31:0]      LINK_VALUE_O,
    output logic [1:0]       BANK_VIEW_O,
    output logic             HALTED_O
);
    logic [31:0] cur_reg;
    logic [31:0] cur_next;
    logic [31:0] saved_reg [NUM_SAVED];
    logic [1:0]  fiq_sync_reg;
    logic [1:0]  irq_sync_reg;
    logic        fiq_req;
    logic        irq_req;
    logic        mode_valid;
    logic        mode_priv;
    logic [2:0]  cur_bank;
    logic [1:0]  cur_view;
    sxc_state_t  state_reg;
    logic        take;
    logic [4:0]  tgt_mode;
    logic [2:0]  tgt_bank;
    logic [31:0] tgt_vec;
    logic [31:0] tgt_ofs;
    logic        tgt_fmask;
    logic        link_pending;
    logic [31:0] fetch_reg;
    logic [31:0] link_reg;
    logic        link_we_reg;
    logic        take_reg;
    logic        cond_res;

    sxc_mode_decode u_mode (
        .mode_i  (cur_reg[MODE_HI:0]),
        .valid_o (mode_valid),
        .priv_o  (mode_priv),
        .bank_o  (cur_bank),
        .view_o  (cur_view)
    );

    // Pins are asynchronous: two flops before any use
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            fiq_sync_reg <= 2'b11;
            irq_sync_reg <= 2'b11;
        end else begin
            fiq_sync_reg <= {fiq_sync_reg[0], FAST_IRQ_IN_N_I};
            irq_sync_reg <= {irq_sync_reg[0], NORMAL_IRQ_IN_N_I};
        end
    end

    assign fiq_req = !fiq_sync_reg[1] && !cur_reg[BIT_FMASK];
    assign irq_req = !irq_sync_reg[1] && !cur_reg[BIT_NMASK];

    // Exceptions are only taken on an instruction boundary
    always_comb begin
        take      = END_OF_INSTR_I && state_reg == ST_RUN;
        tgt_mode  = MODE_SVC;
        tgt_bank  = BANK_SVC;
        tgt_vec   = VEC_TRAP;
        tgt_ofs   = cur_reg[BIT_STATE] ? OFS_2 : OFS_4;
        tgt_fmask = cur_reg[BIT_FMASK];
        if (DATA_ABORT_I) begin
            tgt_mode = MODE_ABT;
            tgt_bank = BANK_ABT;
            tgt_vec  = VEC_DABT;
            tgt_ofs  = OFS_8;
        end else if (fiq_req) begin
            tgt_mode  = MODE_FIQ;
            tgt_bank  = BANK_FIQ;
            tgt_vec   = VEC_FIQ;
            tgt_ofs   = OFS_4;
            tgt_fmask = 1'b1;
        end else if (irq_req) begin
            tgt_mode = MODE_IRQ;
            tgt_bank = BANK_IRQ;
            tgt_vec  = VEC_IRQ;
            tgt_ofs  = OFS_4;
        end else if (PREFETCH_ABORT_I) begin
            tgt_mode = MODE_ABT;
            tgt_bank = BANK_ABT;
            tgt_vec  = VEC_PABT;
            tgt_ofs  = OFS_4;
        end else if (UNDEF_INSTR_I) begin
            tgt_mode = MODE_UND;
            tgt_bank = BANK_UND;
            tgt_vec  = VEC_UND;
        end else if (!SOFTWARE_TRAP_I) begin
            take = 1'b0;
        end
    end

    // Undefined and aborts keep the normal mask; trap and interrupts set it
    function automatic logic keep_nmask(input logic [4:0] m);
        keep_nmask = (m == MODE_UND) || (m == MODE_ABT);
    endfunction : keep_nmask

    always_comb begin
        cur_next = cur_reg;
        if (take) begin
            cur_next[MODE_HI:0] = tgt_mode;
            cur_next[BIT_STATE] = 1'b0;
            cur_next[BIT_FMASK] = tgt_fmask;
            if (!keep_nmask(tgt_mode)) begin
                cur_next[BIT_NMASK] = 1'b1;
            end
        end else if (RETURN_I && cur_bank != BANK_NONE) begin
            cur_next = saved_reg[cur_bank];
        end else begin
            if (FLAGS_WE_I) begin
                cur_next[FLAG_N:FLAG_V] = FLAGS_I;
            end
            if (STATUS_WR_I && !STATUS_WR_SAVED_I) begin
                cur_next = (cur_reg & ~FLAG_FIELD) | (STATUS_WDATA_I & FLAG_FIELD);
                if (mode_priv) begin
                    cur_next[CTRL_HI:0] = STATUS_WDATA_I[CTRL_HI:0];
                    // Direct state writes are left undefined; keep the old bit
                    cur_next[BIT_STATE] = cur_reg[BIT_STATE];
                end
            end
            if (STATE_SET_I) begin
                cur_next[BIT_STATE] = STATE_VALUE_I;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            cur_reg <= RESET_WORD;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // Saved words are unknown after reset in real use; zeroed here
    for (genvar b = 0; b < NUM_SAVED; b++) begin : g_saved
        always_ff @(posedge CLK_SYS_I) begin
            if (!RESETN_I) begin
                saved_reg[b] <= 32'h0000_0000;
            end else if (take && tgt_bank == 3'(b)) begin
                saved_reg[b] <= cur_reg;
            end else if (STATUS_WR_I && STATUS_WR_SAVED_I && cur_bank == 3'(b)) begin
                saved_reg[b] <= STATUS_WDATA_I;
            end
        end
    end

    assign link_pending = take || (BRANCH_WITH_LINK_I && END_OF_INSTR_I);

    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            fetch_reg   <= VEC_RESET;
            link_reg    <= 32'h0000_0000;
            link_we_reg <= 1'b0;
            take_reg    <= 1'b0;
        end else begin
            take_reg    <= take;
            link_we_reg <= link_pending && state_reg == ST_RUN;
            if (take) begin
                fetch_reg <= tgt_vec;
                link_reg  <= PC_I + tgt_ofs;
            end else if (BRANCH_WITH_LINK_I && END_OF_INSTR_I) begin
                link_reg <= PC_I + (cur_reg[BIT_STATE] ? OFS_2 : OFS_4);
            end
            if (RETURN_I && !take) begin
                case (RETURN_KIND_I)
                    EXC_DABT: fetch_reg <= LINK_VALUE_I - OFS_8;
                    EXC_IRQ, EXC_FIQ, EXC_PABT: fetch_reg <= LINK_VALUE_I - OFS_4;
                    default: fetch_reg <= LINK_VALUE_I - OFS_0;
                endcase
            end
        end
    end

    // An illegal mode code parks the controller until reset
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESETN_I) begin
            state_reg <= ST_RUN;
        end else begin
            case (state_reg)
                ST_RUN: state_reg <= !mode_valid ? ST_HALT : (take ? ST_ENTER : ST_RUN);
                ST_ENTER: state_reg <= ST_RUN;
                ST_HALT: state_reg <= ST_HALT;
                default: state_reg <= ST_HALT;
            endcase
        end
    end

    always_comb begin
        case (COND_CODE_I)
            4'h0: cond_res = cur_reg[FLAG_Z];
            4'h1: cond_res = !cur_reg[FLAG_Z];
            4'h2: cond_res = cur_reg[FLAG_C];
            4'h3: cond_res = !cur_reg[FLAG_C];
            4'h4: cond_res = cur_reg[FLAG_N];
            4'h5: cond_res = !cur_reg[FLAG_N];
            4'h6: cond_res = cur_reg[FLAG_V];
            4'h7: cond_res = !cur_reg[FLAG_V];
            4'h8: cond_res = cur_reg[FLAG_C] && !cur_reg[FLAG_Z];
            4'h9: cond_res = !cur_reg[FLAG_C] || cur_reg[FLAG_Z];
            4'hA: cond_res = cur_reg[FLAG_N] == cur_reg[FLAG_V];
            4'hB: cond_res = cur_reg[FLAG_N] != cur_reg[FLAG_V];
            4'hC: cond_res = !cur_reg[FLAG_Z] && cur_reg[FLAG_N] == cur_reg[FLAG_V];
            4'hD: cond_res = cur_reg[FLAG_Z] || cur_reg[FLAG_N] != cur_reg[FLAG_V];
            default: cond_res = 1'b1;
        endcase
    end

    // Compressed code only conditions branches; others always pass
    assign COND_PASS_O = (!cur_reg[BIT_STATE] || COND_BRANCH_I) ? cond_res : 1'b1;

    assign CURRENT_STATUS_WORD_O = cur_reg;
    assign SAVED_STATUS_WORD_O   = (cur_bank != BANK_NONE) ? saved_reg[cur_bank]
                                                           : 32'h0000_0000;
    assign SAVED_VALID_O         = cur_bank != BANK_NONE;
    assign STATE_OUTPUT_SIGNAL_O = cur_reg[BIT_STATE];
    assign EXC_TAKE_O            = take_reg;
    assign FETCH_ADDR_O          = fetch_reg;
    assign LINK_WE_O             = link_we_reg;
    assign LINK_VALUE_O          = link_reg;
    assign BANK_VIEW_O           = cur_view;
    assign HALTED_O              = state_reg == ST_HALT;

    fiq_entry_masks_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        take && tgt_mode == MODE_FIQ |=> cur_reg[BIT_FMASK] && cur_reg[BIT_NMASK])
        else $error("Fast entry did not set both masks");
    state_cleared_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        take |=> !STATE_OUTPUT_SIGNAL_O && FETCH_ADDR_O == $past(tgt_vec))
        else $error("Entry left state bit or vector wrong");
    saved_copy_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        take |=> saved_reg[$past(tgt_bank)] == $past(cur_reg))
        else $error("Saved word not captured on entry");
    mode_forced_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        take |=> cur_reg[MODE_HI:0] == $past(tgt_mode))
        else $error("Mode not forced on entry");
    dabt_link_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        take && DATA_ABORT_I |=> LINK_VALUE_O == $past(PC_I) + OFS_8 && LINK_WE_O)
        else $error("Data abort link value wrong");
    fiq_masked_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        cur_reg[BIT_FMASK] && cur_reg[BIT_NMASK] && !DATA_ABORT_I && !PREFETCH_ABORT_I
        && !UNDEF_INSTR_I && !SOFTWARE_TRAP_I |-> !take)
        else $error("Masked interrupt was taken");
    user_ctrl_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        cur_reg[MODE_HI:0] == MODE_USR && !take && !RETURN_I && !STATE_SET_I
        |=> cur_reg[CTRL_HI:0] == $past(cur_reg[CTRL_HI:0]))
        else $error("User write changed control bits");
    restore_word_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        RETURN_I && !take && cur_bank != BANK_NONE |=> cur_reg == $past(saved_reg[cur_bank]))
        else $error("Return did not restore status word");
    fiq_first_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        take && fiq_req && irq_req && !DATA_ABORT_I |=> cur_reg[MODE_HI:0] == MODE_FIQ)
        else $error("Normal interrupt beat fast interrupt");
endmodule : sxc_status_ctrl
`default_nettype wire

//--- hdl/sxc_pkg.sv
/*
 Status and exception control package: status-word layout, mode codes,
 vectors, link offsets and exception kinds.
 Assumes a single core clock domain; no bus of its own.
*/
package sxc_pkg;
    localparam int          FLAG_N      = 31;
    localparam int          FLAG_Z      = 30;
    localparam int          FLAG_C      = 29;
    localparam int          FLAG_V      = 28;
    localparam int          BIT_NMASK   = 7;
    localparam int          BIT_FMASK   = 6;
    localparam int          BIT_STATE   = 5;
    localparam int          MODE_HI     = 4;
    localparam int          CTRL_HI     = 7;
    localparam int          NUM_SAVED   = 5;
    localparam logic [31:0] FLAG_FIELD  = 32'hF000_0000;
    localparam logic [31:0] CTRL_FIELD  = 32'h0000_00FF;
    localparam logic [4:0]  MODE_USR    = 5'h10;
    localparam logic [4:0]  MODE_FIQ    = 5'h11;
    localparam logic [4:0]  MODE_IRQ    = 5'h12;
    localparam logic [4:0]  MODE_SVC    = 5'h13;
    localparam logic [4:0]  MODE_ABT    = 5'h17;
    localparam logic [4:0]  MODE_UND    = 5'h1B;
    localparam logic [4:0]  MODE_SYS    = 5'h1F;
    localparam logic [31:0] RESET_WORD  = 32'h0000_00D3;
    localparam logic [31:0] VEC_RESET   = 32'h0000_0000;
    localparam logic [31:0] VEC_UND     = 32'h0000_0004;
    localparam logic [31:0] VEC_TRAP    = 32'h0000_0008;
    localparam logic [31:0] VEC_PABT    = 32'h0000_000C;
    localparam logic [31:0] VEC_DABT    = 32'h0000_0010;
    localparam logic [31:0] VEC_RSVD    = 32'h0000_0014;
    localparam logic [31:0] VEC_IRQ     = 32'h0000_0018;
    localparam logic [31:0] VEC_FIQ     = 32'h0000_001C;
    localparam logic [31:0] OFS_2       = 32'h0000_0002;
    localparam logic [31:0] OFS_4       = 32'h0000_0004;
    localparam logic [31:0] OFS_8       = 32'h0000_0008;
    localparam logic [31:0] OFS_0       = 32'h0000_0000;
    // Saved-word bank index per exception mode
    localparam logic [2:0]  BANK_FIQ    = 3'h0;
    localparam logic [2:0]  BANK_IRQ    = 3'h1;
    localparam logic [2:0]  BANK_SVC    = 3'h2;
    localparam logic [2:0]  BANK_ABT    = 3'h3;
    localparam logic [2:0]  BANK_UND    = 3'h4;
    localparam logic [2:0]  BANK_NONE   = 3'h7;
    // Exception kind codes on the return port
    localparam logic [2:0]  EXC_UND     = 3'h1;
    localparam logic [2:0]  EXC_TRAP    = 3'h2;
    localparam logic [2:0]  EXC_PABT    = 3'h3;
    localparam logic [2:0]  EXC_DABT    = 3'h4;
    localparam logic [2:0]  EXC_IRQ     = 3'h5;
    localparam logic [2:0]  EXC_FIQ     = 3'h6;
    localparam logic [2:0]  EXC_BLINK   = 3'h7;
    // Register-bank view: bit0 fast bank r8-r14, bit1 private r13/r14
    localparam logic [1:0]  VIEW_SHARED = 2'h0;
    localparam logic [1:0]  VIEW_FAST   = 2'h3;
    localparam logic [1:0]  VIEW_PRIV   = 2'h2;
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_ENTER = 3'b010,
        ST_HALT  = 3'b100
    } sxc_state_t;
endpackage : sxc_pkg

//--- hdl/sxc_mode_decode.sv
/*
 Mode field decoder: validity, privilege, saved-word bank and register view.
 Assumes a purely combinational use by the status-word controller.
*/
`timescale 1ns/10ps
`default_nettype none
module sxc_mode_decode
    import sxc_pkg::*;
(
    input  wire logic [4:0] mode_i,
    output logic            valid_o,
    output logic            priv_o,
    output logic [2:0]      bank_o,
    output logic [1:0]      view_o
);
    always_comb begin
        valid_o = 1'b1;
        priv_o  = 1'b1;
        bank_o  = BANK_NONE;
        view_o  = VIEW_PRIV;
        case (mode_i)
            MODE_USR: begin
                priv_o = 1'b0;
                view_o = VIEW_SHARED;
            end
            MODE_SYS: view_o = VIEW_SHARED;
            MODE_FIQ: begin
                bank_o = BANK_FIQ;
                view_o = VIEW_FAST;
            end
            MODE_IRQ: bank_o = BANK_IRQ;
            MODE_SVC: bank_o = BANK_SVC;
            MODE_ABT: bank_o = BANK_ABT;
            MODE_UND: bank_o = BANK_UND;
            default: begin
                valid_o = 1'b0;
                view_o  = VIEW_SHARED;
            end
        endcase
    end
endmodule : sxc_mode_decode
`default_nettype wire

//--- tb/sxc_irq_src.sv
/*
 Interrupt source model: drives the two active-low request lines.
 Assumes the bench raises requests and the core reports its entries.
*/
`timescale 1ns/10ps
`default_nettype none
module sxc_irq_src
    import sxc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       fast_req_i,
    input  wire logic       norm_req_i,
    input  wire logic       take_i,
    input  wire logic [4:0] mode_i,
    output var  logic       fast_n_o,
    output var  logic       norm_n_o
);
    // Lines idle high as with a pull-up; a request holds low until its entry
    initial begin
        fast_n_o = 1'b1;
        norm_n_o = 1'b1;
    end
    always @(posedge clk_i) begin
        if (fast_req_i) fast_n_o <= 1'b0;
        else if (take_i && mode_i == MODE_FIQ) fast_n_o <= 1'b1;
        if (norm_req_i) norm_n_o <= 1'b0;
        else if (take_i && mode_i == MODE_IRQ) norm_n_o <= 1'b1;
    end
endmodule : sxc_irq_src
`default_nettype wire

//--- tb/status_and_exception_control_tb.sv
/*
 Bench of the status and exception controller: a table of entries, then
 interrupts, returns, status writes, halt and reset by hand.
 Assumes sxc_irq_src as the far-side interrupt source.
*/
`timescale 1ns/10ps
`default_nettype none
module status_and_exception_control_tb
    import sxc_pkg::*;
;
    typedef struct packed {
        logic [7:0] ctl;
        logic [4:0] cs;
        logic [7:0] ectl;
        logic [7:0] efet;
        logic [7:0] eofs;
    } sxc_row_t;
    logic        clk, rstn, eoi, fwe, swr, swrs, sset, sval, ret, cbr, freq, nreq;
    logic        fast_n, norm_n, svalid, st_out, cpass, take, lwe, halted;
    logic [4:0]  cause;
    logic [3:0]  flags, ccode;
    logic [2:0]  rkind;
    logic [1:0]  view;
    logic [31:0] pc, wdata, link_in, cur, saved, fetch, link;
    int          fails = 0, tests_run = 0, cycles = 0;
    // Cause bits: data abort, prefetch abort, undefined, trap, branch-link
    sxc_row_t    rows [9] = '{
        '{8'h13, 5'h10, 8'h17, 8'h10, 8'h08}, '{8'h33, 5'h08, 8'h17, 8'h0C, 8'h04},
        '{8'h73, 5'h04, 8'h5B, 8'h04, 8'h02}, '{8'h13, 5'h02, 8'h93, 8'h08, 8'h04},
        '{8'h33, 5'h02, 8'h93, 8'h08, 8'h02}, '{8'h13, 5'h1C, 8'h17, 8'h10, 8'h08},
        '{8'h53, 5'h0C, 8'h57, 8'h0C, 8'h04}, '{8'h33, 5'h01, 8'h33, 8'h00, 8'h02},
        '{8'h13, 5'h01, 8'h13, 8'h00, 8'h04}};
    logic [4:0]  mtab [7] = '{MODE_FIQ, MODE_IRQ, MODE_SVC, MODE_ABT, MODE_UND,
                              MODE_SYS, MODE_USR};
    logic [1:0]  vtab [7] = '{VIEW_FAST, VIEW_PRIV, VIEW_PRIV, VIEW_PRIV, VIEW_PRIV,
                              VIEW_SHARED, VIEW_SHARED};

    sxc_status_ctrl uut (
        .CLK_SYS_I(clk), .RESETN_I(rstn), .FAST_IRQ_IN_N_I(fast_n),
        .NORMAL_IRQ_IN_N_I(norm_n), .END_OF_INSTR_I(eoi), .PC_I(pc),
        .DATA_ABORT_I(cause[4]), .PREFETCH_ABORT_I(cause[3]), .UNDEF_INSTR_I(cause[2]),
        .SOFTWARE_TRAP_I(cause[1]), .BRANCH_WITH_LINK_I(cause[0]), .FLAGS_WE_I(fwe),
        .FLAGS_I(flags), .STATUS_WR_I(swr), .STATUS_WR_SAVED_I(swrs),
        .STATUS_WDATA_I(wdata), .STATE_SET_I(sset), .STATE_VALUE_I(sval),
        .RETURN_I(ret), .RETURN_KIND_I(rkind), .LINK_VALUE_I(link_in),
        .COND_BRANCH_I(cbr), .COND_CODE_I(ccode), .CURRENT_STATUS_WORD_O(cur),
        .SAVED_STATUS_WORD_O(saved), .SAVED_VALID_O(svalid),
        .STATE_OUTPUT_SIGNAL_O(st_out), .COND_PASS_O(cpass), .EXC_TAKE_O(take),
        .FETCH_ADDR_O(fetch), .LINK_WE_O(lwe), .LINK_VALUE_O(link),
        .BANK_VIEW_O(view), .HALTED_O(halted));
    sxc_irq_src irq_src (.clk_i(clk), .fast_req_i(freq), .norm_req_i(nreq), .take_i(take),
        .mode_i(cur[4:0]), .fast_n_o(fast_n), .norm_n_o(norm_n));

    task automatic conclude();
        $display("Counts: %0d checks, %0d mismatches", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wr(input logic [31:0] d, input logic s);
        swr = 1'b1;
        swrs = s;
        wdata = d;
        cyc(1);
        swr = 1'b0;
        swrs = 1'b0;
        cyc(1);
    endtask : wr
    task automatic setst(input logic v);
        sset = 1'b1;
        sval = v;
        cyc(1);
        sset = 1'b0;
    endtask : setst
    // Checks follow at the next falling edge, where the one-cycle pulses stand
    task automatic bnd(input logic [4:0] c, input logic [31:0] p);
        eoi = 1'b1;
        cause = c;
        pc = p;
        cyc(1);
        eoi = 1'b0;
        cause = 5'h00;
    endtask : bnd
    task automatic rtn(input logic [2:0] k, input logic [31:0] l);
        ret = 1'b1;
        rkind = k;
        link_in = l;
        cyc(1);
        ret = 1'b0;
        cyc(1);
    endtask : rtn
    task automatic cond(input logic b, input logic [3:0] c, input logic e);
        cbr = b;
        ccode = c;
        cyc(1);
        chk({31'h0, cpass}, {31'h0, e});
    endtask : cond

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // The run needs some 124 cycles; a hang is stopped at the 3000-cycle ceiling, well above
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        {rstn, eoi, fwe, swr, swrs, sset, sval, ret, cbr, freq, nreq} = '0;
        {cause, flags, ccode, rkind, pc, wdata, link_in} = '0;
        cyc(6);
        rstn = 1'b1;
        cyc(1);
        chk(cur, RESET_WORD);
        foreach (rows[i]) begin
            // Status writes carry the current state bit back and keep reserved bits zero
            wr({4'hA, 20'h0_0000, rows[i].ctl[7:6], st_out, rows[i].ctl[4:0]}, 1'b0);
            setst(rows[i].ctl[5]);
            bnd(rows[i].cs, 32'h0000_1000);
            chk(cur, {4'hA, 20'h0_0000, rows[i].ectl});
            chk(link, 32'h0000_1000 + rows[i].eofs);
            if (!rows[i].cs[0]) begin
                chk(fetch, {24'h00_0000, rows[i].efet});
                chk(saved, {4'hA, 20'h0_0000, rows[i].ctl});
                chk({take, lwe, 30'h0}, 32'hC000_0000);
            end
            cyc(2);
        end
        $display("Entry table done");
        wr(32'h5000_00D7, 1'b1);
        chk(saved, 32'h5000_00D7);
        rtn(3'h4, 32'h0000_2000);
        chk(fetch, 32'h0000_1FF8);
        chk(cur, 32'h5000_00D7);
        chk({30'h0, view}, 32'h0000_0002);
        $display("Saved word and return done");
        wr(32'h0000_0053, 1'b0);
        {freq, nreq} = 2'b11;
        cyc(1);
        {freq, nreq} = 2'b00;
        cyc(3);
        bnd(5'h00, 32'h0000_3000);
        chk(cur, 32'h0000_00D2);
        chk(fetch, VEC_IRQ);
        chk(link, 32'h0000_3004);
        cyc(2);
        nreq = 1'b1;
        cyc(1);
        nreq = 1'b0;
        wr(32'h0000_0012, 1'b0);
        cyc(2);
        bnd(5'h00, 32'h0000_5000);
        chk(cur, 32'h0000_00D1);
        chk(fetch, VEC_FIQ);
        chk(saved, 32'h0000_0012);
        chk({30'h0, view}, 32'h0000_0003);
        cyc(2);
        bnd(5'h00, 32'h0000_6000);
        chk(cur, 32'h0000_00D1);
        rtn(3'h6, 32'h0000_5004);
        chk(fetch, 32'h0000_5000);
        chk(cur, 32'h0000_0012);
        cyc(2);
        bnd(5'h00, 32'h0000_7000);
        chk(cur, 32'h0000_0092);
        $display("Interrupts done");
        fwe = 1'b1;
        flags = 4'h4;
        cyc(1);
        fwe = 1'b0;
        chk(cur, 32'h4000_0092);
        cond(1'b0, 4'h0, 1'b1);
        cond(1'b0, 4'h1, 1'b0);
        setst(1'b1);
        chk({31'h0, st_out}, 32'h0000_0001);
        cond(1'b0, 4'h1, 1'b1);
        cond(1'b1, 4'h1, 1'b0);
        setst(1'b0);
        for (int i = 0; i < 7; i++) begin
            wr({24'h00_0000, 3'h6, mtab[i]}, 1'b0);
            chk(cur, {24'h00_0000, 3'h6, mtab[i]});
            chk({30'h0, view}, {30'h0, vtab[i]});
        end
        wr(32'hF000_001F, 1'b0);
        chk(cur, 32'hF000_00D0);
        chk({31'h0, svalid}, 32'h0000_0000);
        bnd(5'h02, 32'h0000_8000);
        chk(cur, 32'hF000_00D3);
        cyc(2);
        wr(32'h0000_00D4, 1'b0);
        chk({31'h0, halted}, 32'h0000_0001);
        bnd(5'h02, 32'h0000_9000);
        chk(cur, 32'h0000_00D4);
        $display("Writes and halt done");
        rstn = 1'b0;
        cyc(6);
        rstn = 1'b1;
        cyc(1);
        chk(cur, RESET_WORD);
        chk({halted, st_out, 30'h0}, 32'h0000_0000);
        chk(fetch, VEC_RESET);
        $display("Reset done");
        conclude();
    end
endmodule : status_and_exception_control_tb
`default_nettype wire
